// ### rtl/clock_output_divider_ctrl.sv
// clock output pin controller with its APB control register
// assumes an APB master on clk_in; the pad cell sits outside
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module clock_output_divider_ctrl (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic pad_data_out,
  output logic pad_oe_n_out,
  output logic pad_ibe_out,
  output logic edge_rate_limit_out,
  output logic pad_drive_boost_out
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    clkout_pkg::run_state_e run_state;
    logic [6:0] trail_cnt;
    logic [31:0] rdata;
    logic err;
  } ctl_s;

  ctl_s state_reg;
  ctl_s state_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic setup;
  logic access;
  logic wr_ctrl;
  logic en_bit;
  logic stop_now;
  logic hit_ctrl;
  logic hit_stat;
  logic [7:0] status;

  clkout_gen_if gen_bus ();

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  // async assert, release synchronised so no flop leaves reset mid-edge
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign hit_ctrl = paddr_in == clkout_pkg::CTRL_ADDR;
  assign hit_stat = paddr_in == clkout_pkg::STAT_ADDR;
  assign wr_ctrl = access && pwrite_in && hit_ctrl;
  assign en_bit = state_reg.ctrl[clkout_pkg::EN_BIT];
  assign stop_now = state_reg.ctrl[clkout_pkg::STOP_BIT];

  always_comb begin
    status = 8'h00;
    status[clkout_pkg::ST_ACTIVE_BIT] = gen_bus.active;
    status[clkout_pkg::ST_TRAIL_BIT] = state_reg.run_state == clkout_pkg::ST_TRAIL;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    // read data and error prepared in setup so the access needs no wait
    if (setup) begin
      state_next.err = !(hit_ctrl || hit_stat) || (pwrite_in && hit_stat);
      if (hit_ctrl) begin
        state_next.rdata = {24'h000000, state_reg.ctrl};
      end else if (hit_stat) begin
        state_next.rdata = {24'h000000, status};
      end else begin
        state_next.rdata = 32'h00000000;
      end
    end
    if (wr_ctrl) begin
      state_next.ctrl = pwdata_in[7:0];
    end
    case (state_reg.run_state)
      clkout_pkg::ST_IDLE: begin
        if (en_bit) begin
          state_next.run_state = clkout_pkg::ST_RUN;
        end
      end
      clkout_pkg::ST_RUN: begin
        if (!en_bit) begin
          state_next.trail_cnt = 7'h00;
          if (stop_now) begin
            state_next.run_state = clkout_pkg::ST_IDLE;
          end else begin
            state_next.run_state = clkout_pkg::ST_TRAIL;
          end
        end
      end
      clkout_pkg::ST_TRAIL: begin
        state_next.trail_cnt = state_reg.trail_cnt + 7'h01;
        if (en_bit) begin
          state_next.run_state = clkout_pkg::ST_RUN;
        end else if (state_reg.trail_cnt == clkout_pkg::TRAIL_LAST) begin
          state_next.run_state = clkout_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next.run_state = clkout_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.ctrl <= clkout_pkg::CTRL_RESET;
      state_reg.run_state <= clkout_pkg::ST_IDLE;
      state_reg.trail_cnt <= 7'h00;
      state_reg.rdata <= 32'h00000000;
      state_reg.err <= 1'b0;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // divider
  // ----------------------------------------
  // the request is level; the divider itself waits for a period end
  assign gen_bus.div_sel = state_reg.ctrl[clkout_pkg::DIV_MSB:clkout_pkg::DIV_LSB];
  assign gen_bus.run = state_reg.run_state != clkout_pkg::ST_IDLE;

  clkout_divider u_divider (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .gen(gen_bus.gen)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // pin low whenever the divider is stopped
  assign pad_data_out = gen_bus.pin_level;
  assign pad_oe_n_out = state_reg.ctrl[clkout_pkg::HIZ_BIT];
  assign pad_ibe_out = 1'b0;
  assign edge_rate_limit_out = state_reg.ctrl[clkout_pkg::SR_BIT];
  // drive boost is left to software even above 8 MHz
  assign pad_drive_boost_out = state_reg.ctrl[clkout_pkg::DS_BIT];
  assign prdata_out = state_reg.rdata;
  assign pready_out = 1'b1;
  assign pslverr_out = access && state_reg.err;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n || !ce_in);

  a_run_starts: assert property (
    en_bit && state_reg.run_state == clkout_pkg::ST_IDLE |=> gen_bus.run)
    else $error("enable did not start the clock");
  a_idle_low: assert property (
    !gen_bus.active && !$past(gen_bus.active) |-> !gen_bus.phase)
    else $error("pin level high while stopped");
  a_trail_len: assert property (
    state_reg.run_state == clkout_pkg::ST_RUN && !en_bit && !stop_now
    |-> ##128 gen_bus.run ##1 (!gen_bus.run || en_bit))
    else $error("trailing clock not 128 cycles");
  a_stop_now: assert property (
    state_reg.run_state == clkout_pkg::ST_RUN && !en_bit && stop_now |=> !gen_bus.run)
    else $error("immediate stop did not drop the request");
  a_float_on: assert property (
    wr_ctrl && pwdata_in[clkout_pkg::HIZ_BIT] |=> pad_oe_n_out && !pad_ibe_out)
    else $error("float select did not release the pad");
  a_drive_pad: assert property (
    wr_ctrl && !pwdata_in[clkout_pkg::HIZ_BIT] |=> !pad_oe_n_out && !pad_ibe_out)
    else $error("pad not in output mode");
  a_slew_follow: assert property (
    wr_ctrl |=> edge_rate_limit_out == $past(pwdata_in[clkout_pkg::SR_BIT]))
    else $error("slew limit not following write");
  a_boost_follow: assert property (
    wr_ctrl |=> pad_drive_boost_out == $past(pwdata_in[clkout_pkg::DS_BIT]))
    else $error("drive boost not following write");
  a_bus_error: assert property (
    access && !(hit_ctrl || hit_stat) |-> pslverr_out)
    else $error("unmapped access without error");
  a_read_back: assert property (
    access && !pwrite_in && hit_ctrl && $past(setup) |-> prdata_out == {24'h000000, state_reg.ctrl})
    else $error("control read back wrong");

  c_trail_done: cover property (
    state_reg.run_state == clkout_pkg::ST_TRAIL && state_reg.trail_cnt == clkout_pkg::TRAIL_LAST);
  c_full_rate: cover property (gen_bus.active && gen_bus.applied_sel == 3'h0);
  c_float_run: cover property (gen_bus.active && pad_oe_n_out);
  c_sel_change: cover property (gen_bus.active && $changed(gen_bus.applied_sel));

endmodule : clock_output_divider_ctrl
`default_nettype wire

// ### rtl/clkout_pkg.sv
// constants shared by the clock output controller and its divider
// assumes a single core clock feeding both modules
package clkout_pkg;

  // ----------------------------------------
  // register map (index; byte address = 4 * index)
  // ----------------------------------------
  localparam logic [11:0] CTRL_IDX = 12'h03C;
  localparam logic [11:0] STAT_IDX = 12'h03E;
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] STAT_ADDR = {STAT_IDX[9:0], 2'b00};

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 2;
  localparam int EN_BIT = 3;
  localparam int DS_BIT = 4;
  localparam int SR_BIT = 5;
  localparam int HIZ_BIT = 6;
  localparam int STOP_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h88;

  // status register fields
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_TRAIL_BIT = 1;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int TRAIL_CYCLES = 128;
  localparam logic [6:0] TRAIL_LAST = 7'(TRAIL_CYCLES - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_TRAIL = 3'b100
  } run_state_e;

  // last count of one half period; ratios 1,2,4,8,32,128,512,976
  function automatic logic [8:0] half_last(input logic [2:0] sel);
    case (sel)
      3'h1: half_last = 9'h000;
      3'h2: half_last = 9'h001;
      3'h3: half_last = 9'h003;
      3'h4: half_last = 9'h00F;
      3'h5: half_last = 9'h03F;
      3'h6: half_last = 9'h0FF;
      3'h7: half_last = 9'h1E7;
      default: half_last = 9'h000;
    endcase
  endfunction : half_last

endpackage : clkout_pkg

// ### rtl/clkout_gen_if.sv
// link between the clock output controller and its divider
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface clkout_gen_if;
  logic [2:0] div_sel;
  logic run;
  logic pin_level;
  logic phase;
  logic active;
  logic boundary;
  logic [2:0] applied_sel;

  modport ctl (output div_sel, output run, input pin_level, input phase,
               input active, input boundary, input applied_sel);
  modport gen (input div_sel, input run, output pin_level, output phase,
               output active, output boundary, output applied_sel);
endinterface : clkout_gen_if
`default_nettype wire

// ### rtl/clkout_divider.sv
// clock divider producing the pad level; settings taken at period ends only
// assumes a synchronised active-low reset and a core clock enable
`timescale 1ns/1ps
`default_nettype none
module clkout_divider (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  clkout_gen_if.gen gen
);

  typedef struct packed {
    logic [8:0] cnt;
    logic phase;
    logic [2:0] sel;
    logic active;
  } div_s;

  div_s state_reg;
  div_s state_next;
  logic gate_neg_reg;
  logic half_end;

  // ----------------------------------------
  // half-period counter
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    half_end = state_reg.cnt == clkout_pkg::half_last(state_reg.sel);
    gen.boundary = !state_reg.active || state_reg.sel == 3'h0 || (!state_reg.phase && half_end);
    if (gen.boundary) begin
      // new settings only where a period ends, so no runt pulse
      state_next.sel = gen.div_sel;
      state_next.active = gen.run;
      state_next.phase = gen.run && gen.div_sel != 3'h0;
      state_next.cnt = 9'h000;
    end else if (half_end) begin
      state_next.phase = 1'b0;
      state_next.cnt = 9'h000;
    end else begin
      state_next.cnt = state_reg.cnt + 9'h001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // full-rate gate changes while the clock is low, the only glitch-free moment
  always_ff @(negedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_neg_reg <= 1'b0;
    end else if (ce_in) begin
      gate_neg_reg <= state_reg.active && state_reg.sel == 3'h0;
    end
  end

  // ratio 1 passes the core clock, others come from the phase flop
  assign gen.pin_level = (state_reg.sel == 3'h0) ? (clk_in & gate_neg_reg) : state_reg.phase;
  assign gen.phase = state_reg.phase;
  assign gen.active = state_reg.active;
  assign gen.applied_sel = state_reg.sel;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_half_four: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    $rose(state_reg.phase) && state_reg.sel == 3'h2 |-> state_reg.phase [*2] ##1 !state_reg.phase)
    else $error("ratio 4 high half is not two cycles");
  a_half_eight: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    $rose(state_reg.phase) && state_reg.sel == 3'h3 |-> state_reg.phase [*4] ##1 !state_reg.phase)
    else $error("ratio 8 high half is not four cycles");
  a_sel_at_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    state_reg.phase && !$past(gen.boundary) |-> $stable(state_reg.sel))
    else $error("divide select changed inside a period");
  c_ratio_976: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(state_reg.phase) && state_reg.sel == 3'h7);

endmodule : clkout_divider
`default_nettype wire

// ### tb/clk_sink_model.sv
// host clock input fed by the output pin: counts rises, measures period and pulses
// assumes a pull-down on the host side while the pad floats
`timescale 1ns/1ps
`default_nettype none
module clk_sink_model (
  input wire logic pad_data_in,
  input wire logic pad_oe_n_in,
  input wire logic clear_in,
  output logic pin_out,
  output var int rises_out,
  output var realtime period_out,
  output var realtime min_pulse_out
);
  realtime t_rise = 0;
  realtime t_fall = 0;
  // released pad settles to the pull-down, never the last driven level
  assign pin_out = pad_oe_n_in ? 1'b0 : pad_data_in;
  initial begin
    rises_out = 0;
    period_out = 0;
    min_pulse_out = 1.0e9;
  end
  always @(posedge clear_in) min_pulse_out = 1.0e9;
  always @(posedge pin_out) begin
    if (t_rise > 0)
      period_out = $realtime - t_rise;
    if (t_fall > 0 && $realtime - t_fall < min_pulse_out)
      min_pulse_out = $realtime - t_fall;
    t_rise = $realtime;
    rises_out = rises_out + 1;
  end
  always @(negedge pin_out) begin
    t_fall = $realtime;
    if (t_rise > 0 && t_fall - t_rise < min_pulse_out)
      min_pulse_out = t_fall - t_rise;
  end
endmodule : clk_sink_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the clock output controller
// assumes the host clock model beside it; ce_in held high except in t_freeze, which drops it for one write
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic ce_in = 1'b1;
  logic reset_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, pad_data_out, pad_oe_n_out, pad_ibe_out;
  logic edge_rate_limit_out, pad_drive_boost_out, clear, pin;
  int rises;
  realtime period, min_pulse;
  int err_total = 0;
  int checks = 0;
  int ratio [8] = '{1, 2, 4, 8, 32, 128, 512, 976};
  logic [31:0] d;
  logic e;
  int n0;

  always #20 clk_in = ~clk_in;

  clock_output_divider_ctrl clock_output_divider_ctrl_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pad_data_out(pad_data_out), .pad_oe_n_out(pad_oe_n_out),
    .pad_ibe_out(pad_ibe_out), .edge_rate_limit_out(edge_rate_limit_out),
    .pad_drive_boost_out(pad_drive_boost_out));
  clk_sink_model clk_sink_model_i (.pad_data_in(pad_data_out), .pad_oe_n_in(pad_oe_n_out),
    .clear_in(clear), .pin_out(pin), .rises_out(rises), .period_out(period), .min_pulse_out(min_pulse));

  task automatic test_done();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one transfer; ends one edge after release so calls never collide
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    int n;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= w;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      test_done();
    end
    d = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task automatic wr(input logic [7:0] v);
    apb(1'b1, clkout_pkg::CTRL_ADDR, {24'h0, v});
  endtask : wr

  task automatic wait_rises(input int n);
    int s = rises;
    int c = 0;
    while (rises < s + n) begin
      @(posedge clk_in);
      c++;
      if (c > 5000) begin
        err_total++;
        test_done();
      end
    end
  endtask : wait_rises

  task automatic t_ratios();
    for (int s = 0; s < 8; s++) begin
      wr(8'h88 | 8'(s) | (s < 2 ? 8'h10 : 8'h00));
      wait_rises(3);
      check(32'($rtoi(period)), 32'(ratio[s] * 40));
      check(32'(pad_drive_boost_out), (s < 2) ? 32'h1 : 32'h0);
    end
  endtask : t_ratios

  task automatic t_retune();
    clear <= 1'b1;
    wr(8'h8B);
    wait_rises(2);
    wr(8'h89);
    wait_rises(3);
    wr(8'h8B);
    wait_rises(3);
    check(32'(min_pulse >= 40.0), 32'h1);
    clear <= 1'b0;
  endtask : t_retune

  task automatic t_stop(input logic [7:0] keep, input int lo, input int hi);
    wr(keep | 8'h0A);
    wait_rises(2);
    n0 = rises;
    wr(keep | 8'h02);
    if (keep == 8'h00) begin
      apb(1'b0, clkout_pkg::STAT_ADDR, 32'h0);
      check(d, 32'h0000_0003);
    end
    repeat (200) @(posedge clk_in);
    check(32'((rises - n0) >= lo && (rises - n0) <= hi), 32'h1);
    check(32'(pad_data_out), 32'h0);
  endtask : t_stop

  task automatic t_pad();
    wr(8'hC8);
    check(32'(pad_oe_n_out), 32'h1);
    check(32'(pad_ibe_out), 32'h0);
    check(32'(pin), 32'h0);
    wr(8'h28);
    check(32'(pad_oe_n_out), 32'h0);
    check(32'(edge_rate_limit_out), 32'h1);
    wr(8'h18);
    check(32'(edge_rate_limit_out), 32'h0);
    check(32'(pad_drive_boost_out), 32'h1);
  endtask : t_pad

  task automatic t_bus();
    apb(1'b0, 12'h004, 32'h0);
    check(d, 32'h0);
    check(32'(e), 32'h1);
    apb(1'b1, clkout_pkg::CTRL_ADDR, 32'hFFFF_FF0B);
    apb(1'b0, clkout_pkg::CTRL_ADDR, 32'h0);
    check(d, 32'h0000_000B);
    apb(1'b1, clkout_pkg::STAT_ADDR, 32'h0);
    check(32'(e), 32'h1);
  endtask : t_bus

  // a write while the enable is low must not land
  task automatic t_freeze();
    ce_in <= 1'b0;
    @(posedge clk_in);
    wr(8'h00);
    ce_in <= 1'b1;
    @(posedge clk_in);
    apb(1'b0, clkout_pkg::CTRL_ADDR, 32'h0);
    check(d, 32'h0000_000B);
  endtask : t_freeze

  initial begin
    clear = 1'b0;
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    apb(1'b0, clkout_pkg::CTRL_ADDR, 32'h0);
    check(d, 32'h0000_0088);
    check(32'(pad_oe_n_out), 32'h0);
    check(32'(pad_ibe_out), 32'h0);
    t_ratios();
    t_retune();
    t_stop(8'h00, 31, 34);
    t_stop(8'h80, 0, 2);
    t_pad();
    t_bus();
    t_freeze();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
